/* File: logic/trig_delay_defines.svh */
/*
   constants for the trigger delay and exposure timer: register offsets, field positions,
   reset values and timing counts.
   assumes a 40 MHz device clock and 32-bit register words, bit 31 being the word's msb.
*/
`ifndef TRIG_DELAY_DEFINES_SVH
`define TRIG_DELAY_DEFINES_SVH

// ----------------------------------------------------------------------------
// register offsets
// ----------------------------------------------------------------------------
`define ADDR_DLY_CAP      32'hF0F0_0534
`define ADDR_DLY_CTL      32'hF0F0_0834
`define ADDR_FINE_DLY     32'hF100_0400

// ----------------------------------------------------------------------------
// field positions (msb-first bit n of the word is data bit 31-n)
// ----------------------------------------------------------------------------
`define BIT_PRESENCE      31
`define BIT_ABS           30
`define BIT_ONE_PUSH      28
`define BIT_READBACK      27
`define BIT_ONOFF_CAP     26
`define BIT_AUTO          25
`define BIT_MANUAL        24
`define BIT_ON            25
`define CAP_MIN_HI        23
`define CAP_MIN_LO        12
`define VAL_HI            11
`define FINE_HI           20

// ----------------------------------------------------------------------------
// reset values and limits
// ----------------------------------------------------------------------------
`define DLY_MIN_VALUE     12'h000
`define DLY_MAX_VALUE     12'hFFF
`define TIMEBASE_RST_US   8'h14
`define SHUTTER_MIN       12'h001
`define EXP_OFFSET_US     12

// ----------------------------------------------------------------------------
// timing
// ----------------------------------------------------------------------------
`define CLK_PERIOD_NS     25
`define US_NS             1000
`define US_CYCLES         (`US_NS / `CLK_PERIOD_NS)

`endif

/* File: logic/trig_delay_pkg.sv */
/*
   types for the trigger delay and exposure timer.
   assumes the constants header is included by the design file.
*/
package trig_delay_pkg;

   // sequencer states, one-hot
   typedef enum logic [5:0] {
      ST_IDLE   = 6'b00_0001,
      ST_DELAY  = 6'b00_0010,
      ST_WAIT   = 6'b00_0100,
      ST_SHUT   = 6'b00_1000,
      ST_PULSE  = 6'b01_0000,
      ST_OFFS   = 6'b10_0000
   } seq_e;

   // register access request
   typedef struct packed {
      logic [31:0] addr;
      logic        wr;
      logic        rd;
      logic [31:0] wdata;
   } reg_req_s;

   // trigger mode controls from outside
   typedef struct packed {
      logic       wr;
      logic       ext_on;
      logic       pw_mode;
      logic       pol;
      logic       pol_capable;
   } trig_cfg_s;

   // all state of the timer
   typedef struct packed {
      seq_e        seq;
      logic        integ;
      logic        dlying;
      logic        dly_on;
      logic        dly_abs;
      logic [11:0] dly_val;
      logic        fine_on;
      logic [20:0] fine_us;
      logic        ext_on;
      logic        pw_mode;
      logic        pol;
      logic [7:0]  timebase;
      logic        act_prev;
      logic [5:0]  tick;
      logic [31:0] us_cnt;
      logic [31:0] rdata;
      logic        ack;
   } state_s;

endpackage

/* File: logic/trig_delay_timer.sv */
/*
   trigger delay and exposure timer: delays integration start after an external trigger
   edge, then times the exposure from the shutter count or from the trigger pulse width.
   assumes the trigger input and all control inputs are synchronous to i_clk, and that
   shutter count and absolute delay are held by logic elsewhere; the timebase is loaded into a register here.
*/
`timescale 1ns/1ps
`include "trig_delay_defines.svh"

module trig_delay_timer #(
   parameter int EXP_OFFSET_US = `EXP_OFFSET_US
) (
   input  wire logic                      i_clk,
   input  wire logic                      i_rst_b,
   input  wire trig_delay_pkg::reg_req_s  i_reg,
   input  wire trig_delay_pkg::trig_cfg_s i_trig_cfg,
   input  wire logic                      i_trig,
   input  wire logic                      i_free_start,
   input  wire logic                      i_readout_busy,
   input  wire logic [11:0]               i_shutter_count,
   input  wire logic [20:0]               i_abs_delay_us,
   input  wire logic                      i_timebase_wr,
   input  wire logic [7:0]                i_timebase_us,
   output logic [31:0]                    o_reg_rdata,
   output logic                           o_reg_ack,
   output logic                           o_integrate,
   output logic                           o_delaying,
   output logic                           o_ext_trig_on,
   output logic                           o_trig_pol
);

   trig_delay_pkg::state_s s_ff;
   trig_delay_pkg::state_s nxt_s;

   logic        act;
   logic        edge_det;
   logic        us_tick;
   logic [11:0] shut_cnt;
   logic [31:0] dly_target;
   logic [31:0] shut_target;
   logic [31:0] cap_word;
   logic [31:0] ctl_word;
   logic [31:0] fine_word;
   logic        sel_ctl;
   logic        sel_fine;

   // ----------------------------------------------------------------------------
   // trigger qualification and targets
   // ----------------------------------------------------------------------------
   // polarity 0 means low-active input
   assign act      = s_ff.pol ? i_trig : ~i_trig;
   assign edge_det = act & ~s_ff.act_prev;
   assign us_tick  = (s_ff.tick == 6'(`US_CYCLES - 1));
   // a zero shutter count would give no exposure, so it is raised to one
   assign shut_cnt = (i_shutter_count < `SHUTTER_MIN) ? `SHUTTER_MIN
                                                      : i_shutter_count;
   assign shut_target = 32'(shut_cnt * s_ff.timebase);
   // fine delay wins over the standard one when both are on
   always_comb begin
      if (s_ff.fine_on) begin
         dly_target = 32'(s_ff.fine_us);
      end else if (s_ff.dly_abs) begin
         dly_target = 32'(i_abs_delay_us);
      end else begin
         dly_target = 32'(s_ff.dly_val * s_ff.timebase);
      end
   end

   // ----------------------------------------------------------------------------
   // read words
   // ----------------------------------------------------------------------------
   // capability flags are constants; auto and one-push are not offered
   always_comb begin
      cap_word = 32'h0000_0000;
      cap_word[`BIT_PRESENCE]  = 1'b1;
      cap_word[`BIT_ABS]       = 1'b1;
      cap_word[`BIT_ONE_PUSH]  = 1'b0;
      cap_word[`BIT_READBACK]  = 1'b1;
      cap_word[`BIT_ONOFF_CAP] = 1'b1;
      cap_word[`BIT_AUTO]      = 1'b0;
      cap_word[`BIT_MANUAL]    = 1'b1;
      cap_word[`CAP_MIN_HI:`CAP_MIN_LO] = `DLY_MIN_VALUE;
      cap_word[`VAL_HI:0]      = `DLY_MAX_VALUE;
      ctl_word = 32'h0000_0000;
      ctl_word[`BIT_PRESENCE]  = 1'b1;
      ctl_word[`BIT_ABS]       = s_ff.dly_abs;
      ctl_word[`BIT_ON]        = s_ff.dly_on;
      ctl_word[`VAL_HI:0]      = s_ff.dly_val;
      fine_word = 32'h0000_0000;
      fine_word[`BIT_PRESENCE] = 1'b1;
      fine_word[`BIT_ON]       = s_ff.fine_on;
      fine_word[`FINE_HI:0]    = s_ff.fine_us;
   end

   assign sel_ctl  = (i_reg.addr == `ADDR_DLY_CTL);
   assign sel_fine = (i_reg.addr == `ADDR_FINE_DLY);

   // ----------------------------------------------------------------------------
   // next state
   // ----------------------------------------------------------------------------
   always_comb begin
      nxt_s = s_ff;
      nxt_s.act_prev = act;
      nxt_s.ack      = i_reg.wr | i_reg.rd;
      nxt_s.tick     = us_tick ? 6'h00 : 6'(s_ff.tick + 6'h01);
      if (us_tick) begin
         nxt_s.us_cnt = s_ff.us_cnt + 32'h0000_0001;
      end

      // register reads answer one cycle later, unmapped reads give zero
      if (i_reg.rd) begin
         if (i_reg.addr == `ADDR_DLY_CAP) begin
            nxt_s.rdata = cap_word;
         end else if (sel_ctl) begin
            nxt_s.rdata = ctl_word;
         end else if (sel_fine) begin
            nxt_s.rdata = fine_word;
         end else begin
            nxt_s.rdata = 32'h0000_0000;
         end
      end

      // other fields only take a write while the feature is already on
      if (i_reg.wr && sel_ctl) begin
         nxt_s.dly_on = i_reg.wdata[`BIT_ON];
         if (s_ff.dly_on) begin
            nxt_s.dly_abs = i_reg.wdata[`BIT_ABS];
            nxt_s.dly_val = i_reg.wdata[`VAL_HI:0];
         end
      end
      if (i_reg.wr && sel_fine) begin
         nxt_s.fine_on = i_reg.wdata[`BIT_ON];
         if (s_ff.fine_on) begin
            nxt_s.fine_us = i_reg.wdata[`FINE_HI:0];
         end
      end

      // trigger mode from outside; delay switch-on forces edge mode
      if (i_trig_cfg.wr) begin
         nxt_s.ext_on  = i_trig_cfg.ext_on;
         nxt_s.pw_mode = i_trig_cfg.pw_mode;
         if (i_trig_cfg.pol_capable) begin
            nxt_s.pol = i_trig_cfg.pol;
         end
      end
      if ((nxt_s.dly_on && !s_ff.dly_on) || (nxt_s.fine_on && !s_ff.fine_on)) begin
         nxt_s.ext_on  = 1'b1;
         nxt_s.pw_mode = 1'b0;
      end
      if (i_timebase_wr) begin
         nxt_s.timebase = i_timebase_us;
      end

      // sequencer; edges outside idle are dropped, so a countdown is never restarted
      case (s_ff.seq)
         trig_delay_pkg::ST_IDLE: begin
            if (s_ff.ext_on && edge_det) begin
               nxt_s.tick   = 6'h00;
               nxt_s.us_cnt = 32'h0000_0000;
               if (s_ff.pw_mode) begin
                  nxt_s.seq = trig_delay_pkg::ST_WAIT;
               end else if (s_ff.dly_on || s_ff.fine_on) begin
                  nxt_s.seq = trig_delay_pkg::ST_DELAY;
               end else begin
                  nxt_s.seq = trig_delay_pkg::ST_SHUT;
               end
            end else if (!s_ff.ext_on && i_free_start) begin
               nxt_s.tick   = 6'h00;
               nxt_s.us_cnt = 32'h0000_0000;
               nxt_s.seq    = trig_delay_pkg::ST_SHUT;
            end
         end
         trig_delay_pkg::ST_DELAY: begin
            if (s_ff.us_cnt >= dly_target) begin
               nxt_s.tick   = 6'h00;
               nxt_s.us_cnt = 32'h0000_0000;
               nxt_s.seq    = trig_delay_pkg::ST_SHUT;
            end
         end
         trig_delay_pkg::ST_WAIT: begin
            // pulse exposure waits out readout, which shows as start jitter
            if (!act) begin
               nxt_s.seq = trig_delay_pkg::ST_IDLE;
            end else if (!i_readout_busy) begin
               nxt_s.seq = trig_delay_pkg::ST_PULSE;
            end
         end
         trig_delay_pkg::ST_SHUT: begin
            if (s_ff.us_cnt >= shut_target) begin
               nxt_s.tick   = 6'h00;
               nxt_s.us_cnt = 32'h0000_0000;
               nxt_s.seq    = trig_delay_pkg::ST_OFFS;
            end
         end
         trig_delay_pkg::ST_PULSE: begin
            // short pulses still give the full offset; nothing clips them
            if (!act) begin
               nxt_s.tick   = 6'h00;
               nxt_s.us_cnt = 32'h0000_0000;
               nxt_s.seq    = trig_delay_pkg::ST_OFFS;
            end
         end
         trig_delay_pkg::ST_OFFS: begin
            if (s_ff.us_cnt >= 32'(EXP_OFFSET_US)) begin
               nxt_s.seq = trig_delay_pkg::ST_IDLE;
            end
         end
         default: begin
            nxt_s.seq = trig_delay_pkg::ST_IDLE;
         end
      endcase

      // output flags come from the next state so each pin leaves a flip-flop
      // directly; decoding the state vector at the pins would add a gate level
      nxt_s.dlying = (nxt_s.seq == trig_delay_pkg::ST_DELAY);
      nxt_s.integ  = (nxt_s.seq == trig_delay_pkg::ST_SHUT) ||
                     (nxt_s.seq == trig_delay_pkg::ST_PULSE) ||
                     (nxt_s.seq == trig_delay_pkg::ST_OFFS);
   end

   // ----------------------------------------------------------------------------
   // state register
   // ----------------------------------------------------------------------------
   always_ff @(posedge i_clk) begin
      if (!i_rst_b) begin
         s_ff.seq      <= trig_delay_pkg::ST_IDLE;
         s_ff.integ    <= 1'b0;
         s_ff.dlying   <= 1'b0;
         s_ff.dly_on   <= 1'b0;
         s_ff.dly_abs  <= 1'b0;
         s_ff.dly_val  <= 12'h000;
         s_ff.fine_on  <= 1'b0;
         s_ff.fine_us  <= 21'h00_0000;
         s_ff.ext_on   <= 1'b0;
         s_ff.pw_mode  <= 1'b0;
         s_ff.pol      <= 1'b1;
         s_ff.timebase <= `TIMEBASE_RST_US;
         s_ff.act_prev <= 1'b1;
         s_ff.tick     <= 6'h00;
         s_ff.us_cnt   <= 32'h0000_0000;
         s_ff.rdata    <= 32'h0000_0000;
         s_ff.ack      <= 1'b0;
      end else begin
         s_ff <= nxt_s;
      end
   end

   // outputs straight from the state register
   assign o_reg_rdata   = s_ff.rdata;
   assign o_reg_ack     = s_ff.ack;
   assign o_integrate   = s_ff.integ;
   assign o_delaying    = s_ff.dlying;
   assign o_ext_trig_on = s_ff.ext_on;
   assign o_trig_pol    = s_ff.pol;

   // ----------------------------------------------------------------------------
   // assertions
   // ----------------------------------------------------------------------------
   default clocking cb @(posedge i_clk); endclocking
   default disable iff (!i_rst_b);

   sequence cap_read_s;
      i_reg.rd && (i_reg.addr == `ADDR_DLY_CAP);
   endsequence

   sequence off_write_s;
      i_reg.wr && sel_ctl && !s_ff.dly_on;
   endsequence

   a_cap_flags_fixed: assert property (
      cap_read_s |=> (o_reg_rdata[31:24] == 8'hCD) && o_reg_ack)
      else $error("capability flags wrong");

   a_cap_limits: assert property (
      cap_read_s |=> o_reg_rdata[11:0] == 12'hFFF)
      else $error("capability maximum wrong");

   a_ctl_presence: assert property (
      i_reg.rd && sel_ctl |=> o_reg_rdata[31])
      else $error("presence bit not set");

   a_off_write_drops: assert property (
      off_write_s ##0 (i_reg.wdata[11:0] != s_ff.dly_val)
      |=> $stable(s_ff.dly_val))
      else $error("value taken while off");

   a_on_forces_edge: assert property (
      $rose(s_ff.dly_on) |-> s_ff.ext_on && !s_ff.pw_mode)
      else $error("delay on without edge mode");

   a_delay_needs_edge: assert property (
      $rose(o_delaying) |-> $past(s_ff.ext_on) && !$past(s_ff.pw_mode))
      else $error("delay outside edge mode");

   a_delay_holds: assert property (
      o_delaying && (s_ff.us_cnt < dly_target) |=> o_delaying)
      else $error("countdown cut short");

   a_tick_period: assert property (
      us_tick |=> !us_tick [*8])
      else $error("microsecond tick too fast");

   // the microsecond count bounds the offset phase, whatever the offset parameter
   a_offset_ends: assert property (
      (s_ff.seq == trig_delay_pkg::ST_OFFS) |-> (s_ff.us_cnt <= 32'(EXP_OFFSET_US)))
      else $error("offset phase does not end");

   a_offset_exit: assert property (
      (s_ff.seq == trig_delay_pkg::ST_OFFS) && (s_ff.us_cnt >= 32'(EXP_OFFSET_US))
      |=> s_ff.seq == trig_delay_pkg::ST_IDLE)
      else $error("offset phase overruns");

   a_pulse_follows: assert property (
      (s_ff.seq == trig_delay_pkg::ST_PULSE) && !act
      |=> s_ff.seq == trig_delay_pkg::ST_OFFS)
      else $error("pulse end not followed by offset");

   // fine delay register always reports itself present
   a_fine_presence: assert property (
      i_reg.rd && sel_fine |=> o_reg_rdata[31])
      else $error("fine presence bit not set");

   // without polarity capability a mode write must leave the polarity alone
   a_pol_locked: assert property (
      i_trig_cfg.wr && !i_trig_cfg.pol_capable |=> $stable(s_ff.pol))
      else $error("polarity changed while locked");

   // pulse exposure holds off while the sensor is read out
   a_readout_wait: assert property (
      (s_ff.seq == trig_delay_pkg::ST_WAIT) && act && i_readout_busy
      |=> (s_ff.seq == trig_delay_pkg::ST_WAIT))
      else $error("pulse exposure began during readout");

   // in external mode only a trigger edge may start anything
   a_ext_no_free: assert property (
      (s_ff.seq == trig_delay_pkg::ST_IDLE) && s_ff.ext_on && !edge_det
      |=> !o_delaying && !o_integrate)
      else $error("start without trigger edge");

endmodule

/* File: tb/trig_source_model.sv */
/*
   model of the external trigger source that drives the timer's trigger input.
   assumes it shares the device clock and that the bench chooses its polarity.
*/
`timescale 1ns/1ps

module trig_source_model (
   input  wire logic i_clk,
   output logic      o_trig
);
   // ----------------------------------------------------------------------------
   // trigger line
   // ----------------------------------------------------------------------------
   logic act_lvl;

   // the line is always driven, idling at the inactive level
   initial begin
      act_lvl = 1'b1;
      o_trig  = 1'b0;
   end

   // idle level moves with polarity, so call this only while edge mode is off
   task automatic set_pol(input logic lvl);
      @(posedge i_clk);
      act_lvl = lvl;
      o_trig <= ~lvl;
   endtask

   // one active pulse; pulse-width users keep it at 20 us or longer
   task automatic pulse(input int width);
      @(posedge i_clk);
      o_trig <= act_lvl;
      repeat (width) @(posedge i_clk);
      o_trig <= ~act_lvl;
   endtask
endmodule

/* File: tb/trig_delay_exposure_timer_tb_top.sv */
/*
   self-checking bench for the trigger delay and exposure timer: register reads and
   writes, delayed edge triggers, pulse-width and free-run exposures, polarity.
   assumes the design files and the trigger source model are compiled first.
*/
`timescale 1ns/1ps

module trig_delay_exposure_timer_tb_top;
   // ----------------------------------------------------------------------------
   // signals
   // ----------------------------------------------------------------------------
   localparam int OFF = 2;
   localparam int US  = 40;
   logic                      i_clk;
   logic                      i_rst_b;
   trig_delay_pkg::reg_req_s  i_reg;
   trig_delay_pkg::trig_cfg_s i_trig_cfg;
   logic                      i_trig;
   logic                      i_free_start;
   logic                      i_readout_busy;
   logic [11:0]               i_shutter_count;
   logic [20:0]               i_abs_delay_us;
   logic                      i_timebase_wr;
   logic [7:0]                i_timebase_us;
   logic [31:0]               o_reg_rdata;
   logic                      o_reg_ack;
   logic                      o_integrate;
   logic                      o_delaying;
   logic                      o_ext_trig_on;
   logic                      o_trig_pol;
   int                        error_cnt = 0;
   int                        checked   = 0;

   // short offset keeps each exposure under a thousand cycles
   trig_delay_timer #(.EXP_OFFSET_US(OFF)) dut_u (
      .i_clk(i_clk), .i_rst_b(i_rst_b), .i_reg(i_reg), .i_trig_cfg(i_trig_cfg),
      .i_trig(i_trig), .i_free_start(i_free_start), .i_readout_busy(i_readout_busy),
      .i_shutter_count(i_shutter_count), .i_abs_delay_us(i_abs_delay_us),
      .i_timebase_wr(i_timebase_wr), .i_timebase_us(i_timebase_us),
      .o_reg_rdata(o_reg_rdata), .o_reg_ack(o_reg_ack), .o_integrate(o_integrate),
      .o_delaying(o_delaying), .o_ext_trig_on(o_ext_trig_on), .o_trig_pol(o_trig_pol));

   trig_source_model src_u (.i_clk(i_clk), .o_trig(i_trig));

   // ----------------------------------------------------------------------------
   // tasks
   // ----------------------------------------------------------------------------
   task automatic chk_word(input string name, input logic [31:0] exp, input logic [31:0] seen);
      checked++;
      if (seen !== exp) begin
         error_cnt++;
         $display("Error %s expected %h seen %h", name, exp, seen);
      end
   endtask

   task automatic chk_range(input string name, input int lo, input int hi, input int seen);
      checked++;
      if (seen < lo || seen > hi) begin
         error_cnt++;
         $display("Error %s expected %0d..%0d seen %0d", name, lo, hi, seen);
      end
   endtask

   // one strobe cycle, answer sampled at the edge after the taking edge
   task automatic reg_acc(input logic w, input logic [31:0] a, input logic [31:0] wd,
                          output logic [31:0] rd);
      @(posedge i_clk);
      i_reg <= '{a, w, ~w, wd};
      @(posedge i_clk);
      i_reg.wr <= 1'b0;
      i_reg.rd <= 1'b0;
      @(posedge i_clk);
      chk_word("ack", 32'h0000_0001, {31'h0, o_reg_ack});
      rd = o_reg_rdata;
   endtask

   task automatic wr(input logic [31:0] a, input logic [31:0] wd);
      logic [31:0] d;
      reg_acc(1'b1, a, wd, d);
   endtask

   task automatic rd_chk(input string name, input logic [31:0] a, input logic [31:0] exp);
      logic [31:0] d;
      reg_acc(1'b0, a, 32'h0000_0000, d);
      chk_word(name, exp, d);
   endtask

   task automatic cfg(input logic ext, input logic pw, input logic pol, input logic cap);
      @(posedge i_clk);
      i_trig_cfg <= '{1'b1, ext, pw, pol, cap};
      @(posedge i_clk);
      i_trig_cfg.wr <= 1'b0;
      @(posedge i_clk);
   endtask

   task automatic free_start();
      @(posedge i_clk);
      i_free_start <= 1'b1;
      @(posedge i_clk);
      i_free_start <= 1'b0;
   endtask

   // counts delay and exposure cycles; tick phase may add up to one microsecond
   task automatic measure(input int dly, input int expo);
      int n;
      int d;
      int e;
      n = 0;
      d = 0;
      e = 0;
      while (o_delaying !== 1'b1 && o_integrate !== 1'b1 && n < 200) begin
         @(posedge i_clk);
         n++;
      end
      while (o_delaying === 1'b1 && d < 200000) begin
         @(posedge i_clk);
         d++;
      end
      while (o_integrate === 1'b1 && e < 200000) begin
         @(posedge i_clk);
         e++;
      end
      chk_range("delay", (dly == 0) ? 0 : dly - 2, (dly == 0) ? 0 : dly + US + 2, d);
      chk_range("exposure", expo - 2, expo + US + 2, e);
   endtask

   task automatic summarize();
      $display("comparisons %0d mismatches %0d", checked, error_cnt);
      if (error_cnt == 0 && checked > 0)
         $display("verification passed");
      else
         $display("verification failed");
      $finish;
   endtask

   // ----------------------------------------------------------------------------
   // clock, watchdog and tests
   // ----------------------------------------------------------------------------
   initial begin
      i_clk = 1'b0;
      forever #12.5 i_clk = ~i_clk;
   end

   // whole run is a few thousand cycles, so this only fires on a hang
   initial begin
      repeat (30000) @(posedge i_clk);
      error_cnt++;
      summarize();
   end

   initial begin
      i_rst_b = 1'b0;
      i_reg = '0;
      i_trig_cfg = '0;
      i_free_start = 1'b0;
      i_readout_busy = 1'b0;
      i_shutter_count = 12'h001;
      i_abs_delay_us = 21'h00_0000;
      i_timebase_wr = 1'b0;
      i_timebase_us = 8'h00;
      repeat (5) @(posedge i_clk);
      i_rst_b <= 1'b1;
      @(posedge i_clk);
      chk_word("pol_rst", 32'h0000_0001, {31'h0, o_trig_pol});
      // free run at the default timebase, smallest shutter count
      fork
         free_start();
         measure(0, (20 + OFF) * US);
      join
      @(posedge i_clk);
      i_timebase_wr <= 1'b1;
      i_timebase_us <= 8'h01;
      i_shutter_count <= 12'h003;
      @(posedge i_clk);
      i_timebase_wr <= 1'b0;
      // register map, reserved and read-only places
      rd_chk("cap", 32'hF0F0_0534, 32'hCD00_0FFF);
      rd_chk("ctl", 32'hF0F0_0834, 32'h8000_0000);
      rd_chk("fine", 32'hF100_0400, 32'h8000_0000);
      rd_chk("unmapped", 32'hF0F0_0530, 32'h0000_0000);
      wr(32'hF0F0_0534, 32'h0000_0000);
      rd_chk("cap_ro", 32'hF0F0_0534, 32'hCD00_0FFF);
      wr(32'hF0F0_0834, 32'h4000_0005);
      rd_chk("ctl_off", 32'hF0F0_0834, 32'h8000_0000);
      chk_word("ext_off", 32'h0000_0000, {31'h0, o_ext_trig_on});
      wr(32'hF0F0_0834, 32'h0200_0002);
      rd_chk("ctl_on", 32'hF0F0_0834, 32'h8200_0000);
      chk_word("ext_on", 32'h0000_0001, {31'h0, o_ext_trig_on});
      wr(32'hF0F0_0834, 32'h0200_0002);
      rd_chk("ctl_val", 32'hF0F0_0834, 32'h8200_0002);
      // standard delay, with a second edge inside the countdown
      fork
         begin
            src_u.pulse(10);
            repeat (30) @(posedge i_clk);
            src_u.pulse(10);
         end
         measure(2 * US, (3 + OFF) * US);
      join
      repeat (20) @(posedge i_clk);
      chk_word("no_retrig", 32'h0000_0000, {31'h0, o_delaying});
      free_start();
      @(posedge i_clk);
      chk_word("free_in_ext", 32'h0000_0000, {31'h0, o_integrate});
      wr(32'hF0F0_0834, 32'h4200_0002);
      i_abs_delay_us <= 21'h00_0004;
      rd_chk("ctl_abs", 32'hF0F0_0834, 32'hC200_0002);
      fork
         src_u.pulse(10);
         measure(4 * US, (3 + OFF) * US);
      join
      wr(32'hF100_0400, 32'h0200_0003);
      rd_chk("fine_first", 32'hF100_0400, 32'h8200_0000);
      wr(32'hF100_0400, 32'h0200_0003);
      rd_chk("fine_on", 32'hF100_0400, 32'h8200_0003);
      fork
         src_u.pulse(10);
         measure(3 * US, (3 + OFF) * US);
      join
      // pulse-width mode ignores the delay
      cfg(1'b1, 1'b1, 1'b1, 1'b0);
      fork
         src_u.pulse(20 * US);
         begin
            // readout busy for the first 100 cycles holds the exposure start back
            i_readout_busy <= 1'b1;
            repeat (100) @(posedge i_clk);
            i_readout_busy <= 1'b0;
         end
         measure(0, (20 + OFF) * US - 100);
      join
      cfg(1'b0, 1'b0, 1'b1, 1'b0);
      fork
         free_start();
         measure(0, (3 + OFF) * US);
      join
      // low-active trigger, polarity writable only when capable
      src_u.set_pol(1'b0);
      cfg(1'b0, 1'b0, 1'b0, 1'b1);
      chk_word("pol_low", 32'h0000_0000, {31'h0, o_trig_pol});
      cfg(1'b1, 1'b0, 1'b1, 1'b0);
      chk_word("pol_kept", 32'h0000_0000, {31'h0, o_trig_pol});
      fork
         src_u.pulse(10);
         measure(3 * US, (3 + OFF) * US);
      join
      wr(32'hF100_0400, 32'h0000_0003);
      wr(32'hF0F0_0834, 32'h4000_0002);
      rd_chk("ctl_off2", 32'hF0F0_0834, 32'hC000_0002);
      fork
         src_u.pulse(10);
         measure(0, (3 + OFF) * US);
      join
      summarize();
   end
endmodule
